// >>> include/seq_pkg.sv
// Shared constants for the pulse-program loop sequencer.
// Assumes a single 100 MHz core clock and event words from a program FIFO.
package seq_pkg;
	// Core clock period in picoseconds
	localparam int CLK_PERIOD_PS = 10000;
	// Fine time base of the main controller, picoseconds
	localparam int FINE_BASE_PS = 12500;
	// Smaller-system time bases, picoseconds
	localparam int SMALL_FAST_BASE_PS = 100000;
	localparam longint SMALL_SLOW_BASE_PS = 64'd1000000000;
	// Sample pair window, picoseconds
	localparam int PAIR_TIME_PS = 200000;
	// Cycles per sample pair window, rounded up
	localparam int PAIR_CYCLES = (PAIR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Loop counter width and largest count
	localparam int LOOP_CNT_W = 16;
	localparam logic [15:0] LOOP_MAX = 16'h7FFF;
	// Event word layout: [63:60] opcode, [59:52] gates, [51:40] aux, [39:0] duration
	localparam int OP_MSB = 63;
	localparam int OP_LSB = 60;
	localparam int GATE_MSB = 59;
	localparam int GATE_LSB = 52;
	localparam int AUX_MSB = 51;
	localparam int AUX_LSB = 40;
	localparam int DUR_MSB = 39;
	localparam int DUR_LSB = 0;
	// Gate bit positions
	localparam int GATE_TX = 0;
	localparam int GATE_AMP = 1;
	// Opcodes
	localparam logic [3:0] OP_EVENT = 4'h0;
	localparam logic [3:0] OP_PULSE = 4'h1;
	localparam logic [3:0] OP_LOOP_START = 4'h2;
	localparam logic [3:0] OP_LOOP_END = 4'h3;
	localparam logic [3:0] OP_ACQUIRE = 4'h4;
	localparam logic [3:0] OP_SEQ_START = 4'h5;
	localparam logic [3:0] OP_SEQ_END = 4'h6;
	localparam logic [3:0] OP_PHASE = 4'h7;
	localparam logic [3:0] OP_OFFSET = 4'h8;
	// Event budget per statement inside a loop
	localparam logic [11:0] COST_PULSE = 12'h003;
	localparam logic [11:0] COST_OFFSET = 12'h009;
	localparam logic [11:0] COST_DELAY = 12'h001;
	localparam logic [11:0] COST_PHASE = 12'h000;
	// Error codes
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_ZERO_LOOP = 3'h1;
	localparam logic [2:0] ERR_NESTED = 3'h2;
	localparam logic [2:0] ERR_POINTS = 3'h3;
	localparam logic [2:0] ERR_LOOP_END = 3'h4;
	localparam logic [2:0] ERR_SHORT_BODY = 3'h5;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_PRE = 3'b001,
		ST_WIDTH = 3'b010,
		ST_POST = 3'b011,
		ST_SAMPLE = 3'b100,
		ST_WAIT = 3'b101,
		ST_HALT = 3'b110
	} seq_state_t;
endpackage

// >>> logic/event_timer.sv
// Event timer: counts one duration on a selectable time base.
// Assumes start pulses come from the sequencer on the same clock.
`timescale 1ns/100ps
module event_timer #(
	parameter int DUR_W = 40,
	parameter int FINE_DIV = 5,
	parameter int SLOW_DIV = 100000
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic slow_base,
	input wire logic [DUR_W-1:0] ticks,
	output logic done
);
	// Tick prescaler and remaining count
	logic [16:0] pre_reg;
	logic [DUR_W-1:0] left_reg;
	logic busy_reg;
	logic [16:0] div_w;
	logic tick_w;
	assign div_w = slow_base ? 17'(SLOW_DIV - 1) : 17'(FINE_DIV - 1);
	assign tick_w = busy_reg && (pre_reg == div_w);

	// Count base ticks, then flag done for one cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pre_reg <= 17'h00000;
			left_reg <= '0;
			busy_reg <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				pre_reg <= 17'h00000;
				left_reg <= ticks;
				busy_reg <= (ticks != '0);
				done <= (ticks == '0);
			end else if (busy_reg) begin
				pre_reg <= tick_w ? 17'h00000 : pre_reg + 17'h00001;
				if (tick_w) begin
					left_reg <= left_reg - 1'b1;
					if (left_reg == {{(DUR_W-1){1'b0}}, 1'b1}) begin
						busy_reg <= 1'b0;
						done <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// >>> logic/loop_sequencer.sv
// Pulse-program sequencer with one hardware loop level and explicit acquisition.
// Assumes event words arrive from the program FIFO with valid/ready on core_clk.
//
// Notes on behaviour
// - Loop control only for counts of two or more
// - Zero repetition count raises an error
// - No nested loops; one level only
// - Event sets gates; zero length gives none
// - Main controller timer counts 12.5 ns
// - Small system: 0.1 us and 1 ms bases
// - Gated pulse is pre, width, post events
// - Pair sampled 200 ns, then interval wait; the small system times the pair as 20 base ticks
// - Overhead sets phase, toggles overflow detection
// - Explicit acquisition disables auto; totals checked
// - Data table zeroed at start or clear
// - Loop of one acquisition is refused
// - Sixteen bit loop counter, max 32767
// - Phase latched at first point of scan
// - Fixed event budget per statement type; acquisition costs its point count
`timescale 1ns/100ps
module loop_sequencer #(
	parameter int LOOP_DEPTH = 2048,
	parameter int PTR_W = 11,
	parameter bit SMALL_SYSTEM = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [63:0] prog_data,
	input wire logic prog_valid,
	output logic prog_ready,
	input wire logic clear_table,
	input wire logic [1:0] rx_phase_in,
	input wire logic [31:0] total_point_count,
	output logic [7:0] gate_out,
	output logic sample_strobe,
	output logic [1:0] rx_phase_out,
	output logic ovf_detect_en,
	output logic auto_acq_en,
	output logic table_clear,
	output logic seq_running,
	output logic [2:0] err_code,
	output logic err_flag,
	output logic [11:0] loop_events
);
	// Base tick dividers for each system
	localparam int FAST_DIV = seq_pkg::SMALL_FAST_BASE_PS / seq_pkg::CLK_PERIOD_PS;
	localparam int SLOW_DIV = int'(seq_pkg::SMALL_SLOW_BASE_PS
		/ seq_pkg::SMALL_FAST_BASE_PS);

	// Loop body store and its pointers
	logic [63:0] body_mem [LOOP_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] body_len_reg;
	logic in_loop_reg;
	logic replay_reg;
	logic [15:0] loop_cnt_reg;
	logic [11:0] budget_reg;
	logic body_acq_only_reg;
	// Sequencer state and current word
	seq_pkg::seq_state_t state_reg;
	logic [63:0] word_reg;
	logic [31:0] pairs_left_reg;
	logic [31:0] points_reg;
	logic phase_locked_reg;
	logic acq_open_reg;
	logic explicit_reg;
	// Timer hookup
	logic tmr_start_reg;
	logic tmr_slow_reg;
	logic [39:0] tmr_ticks_reg;
	logic tmr_done;
	// Decoded fields of the word being taken
	logic [63:0] cur_w;
	logic [3:0] op_w;
	logic [39:0] dur_w;
	logic [11:0] aux_w;
	logic take_w;
	logic replay_end_w; // Whole body replayed, serve a loop end
	logic fetch_w;
	logic [11:0] cost_w;

	// Replay from the body store, otherwise take from the program FIFO; once the whole
	// body has been replayed a loop end is served, because the store never holds one
	assign replay_end_w = replay_reg && ({1'b0, rd_ptr_reg} == body_len_reg);
	assign cur_w = replay_end_w ? {seq_pkg::OP_LOOP_END, 60'h000000000000000}
		: (replay_reg ? body_mem[rd_ptr_reg] : prog_data);
	assign op_w = cur_w[seq_pkg::OP_MSB:seq_pkg::OP_LSB];
	assign dur_w = cur_w[seq_pkg::DUR_MSB:seq_pkg::DUR_LSB];
	assign aux_w = cur_w[seq_pkg::AUX_MSB:seq_pkg::AUX_LSB];
	assign fetch_w = (state_reg == seq_pkg::ST_FETCH) && !tmr_start_reg;
	// A FIFO word counts as taken only where valid meets the registered ready
	assign take_w = fetch_w && (replay_reg || (prog_valid && prog_ready));
	assign cost_w = event_cost(op_w, aux_w);

	// Event budget that a statement uses inside a loop
	function automatic logic [11:0] event_cost(input logic [3:0] op, input logic [11:0] aux);
		unique case (op)
			seq_pkg::OP_PULSE: event_cost = seq_pkg::COST_PULSE;
			seq_pkg::OP_OFFSET: event_cost = seq_pkg::COST_OFFSET;
			seq_pkg::OP_PHASE: event_cost = seq_pkg::COST_PHASE;
			seq_pkg::OP_ACQUIRE: event_cost = aux;
			default: event_cost = seq_pkg::COST_DELAY;
		endcase
	endfunction

	// Fine ticks are 12.5 ns, which the 10 ns core clock cannot count one to one,
	// so they become core cycles, rounded up; small-system ticks pass as they are
	function automatic logic [39:0] ticks_of(input logic [39:0] d);
		logic [63:0] ps;
		ps = 64'(d) * 64'(seq_pkg::FINE_BASE_PS) + 64'(seq_pkg::CLK_PERIOD_PS - 1);
		ticks_of = SMALL_SYSTEM ? d : 40'(ps / 64'(seq_pkg::CLK_PERIOD_PS));
	endfunction

	// Ready only while fetching fresh words; low for the cycle after a take, so a
	// raised ready always means the next offered word is accepted
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prog_ready <= 1'b0;
		end else begin
			prog_ready <= fetch_w && !take_w && !replay_reg && !err_flag;
		end
	end

	// Body store writes while a loop is being recorded
	always_ff @(posedge core_clk) begin
		if (take_w && !replay_reg && in_loop_reg && op_w != seq_pkg::OP_LOOP_END) begin
			body_mem[wr_ptr_reg] <= cur_w;
		end
	end

	// Main sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= seq_pkg::ST_FETCH;
			word_reg <= 64'h0000000000000000;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			body_len_reg <= '0;
			in_loop_reg <= 1'b0;
			replay_reg <= 1'b0;
			loop_cnt_reg <= 16'h0000;
			budget_reg <= 12'h000;
			body_acq_only_reg <= 1'b0;
			pairs_left_reg <= 32'h00000000;
			points_reg <= 32'h00000000;
			phase_locked_reg <= 1'b0;
			acq_open_reg <= 1'b0;
			explicit_reg <= 1'b0;
			tmr_start_reg <= 1'b0;
			tmr_slow_reg <= 1'b0;
			tmr_ticks_reg <= 40'h0000000000;
			gate_out <= 8'h00;
			sample_strobe <= 1'b0;
			rx_phase_out <= 2'h0;
			ovf_detect_en <= 1'b0;
			auto_acq_en <= 1'b1;
			table_clear <= 1'b0;
			seq_running <= 1'b0;
			err_code <= seq_pkg::ERR_NONE;
			err_flag <= 1'b0;
			loop_events <= 12'h000;
		end else begin
			tmr_start_reg <= 1'b0;
			sample_strobe <= 1'b0;
			table_clear <= clear_table;
			unique case (state_reg)
				seq_pkg::ST_FETCH: begin
					if (take_w && !err_flag) begin
						word_reg <= cur_w;
						tmr_slow_reg <= SMALL_SYSTEM && cur_w[seq_pkg::AUX_LSB];
						if (replay_reg) begin
							rd_ptr_reg <= rd_ptr_reg + 1'b1;
						end
						if (in_loop_reg && !replay_reg && op_w != seq_pkg::OP_LOOP_END) begin
							wr_ptr_reg <= wr_ptr_reg + 1'b1;
							budget_reg <= budget_reg + cost_w;
							body_acq_only_reg <= (body_len_reg == '0) && (op_w == seq_pkg::OP_ACQUIRE);
							body_len_reg <= body_len_reg + 1'b1;
						end
						unique case (op_w)
							seq_pkg::OP_SEQ_START: begin
								seq_running <= 1'b1;
								table_clear <= 1'b1;
								points_reg <= 32'h00000000;
								explicit_reg <= 1'b0;
								auto_acq_en <= 1'b1;
								phase_locked_reg <= 1'b0;
							end
							seq_pkg::OP_SEQ_END: begin
								seq_running <= 1'b0;
								if (acq_open_reg) begin
									ovf_detect_en <= 1'b0;
									acq_open_reg <= 1'b0;
								end
								if (explicit_reg && points_reg != total_point_count) begin
									err_code <= seq_pkg::ERR_POINTS;
									err_flag <= 1'b1;
								end
							end
							seq_pkg::OP_LOOP_START: begin
								if (in_loop_reg) begin
									err_code <= seq_pkg::ERR_NESTED;
									err_flag <= 1'b1;
								end else if (dur_w[15:0] == 16'h0000) begin
									err_code <= seq_pkg::ERR_ZERO_LOOP;
									err_flag <= 1'b1;
								end else if (dur_w[15:0] != 16'h0001) begin
									// Counter is 16 bits; counts above the limit clamp
									loop_cnt_reg <= (dur_w[15:0] > seq_pkg::LOOP_MAX)
										? seq_pkg::LOOP_MAX : dur_w[15:0];
									in_loop_reg <= 1'b1;
									wr_ptr_reg <= '0;
									body_len_reg <= '0;
									budget_reg <= 12'h000;
								end
							end
							seq_pkg::OP_LOOP_END: begin
								if (!in_loop_reg) begin
									// A count of one opened no loop, so its end passes
								end else if (body_len_reg < 2 || body_acq_only_reg) begin
									err_code <= seq_pkg::ERR_SHORT_BODY;
									err_flag <= 1'b1;
								end else if (loop_cnt_reg == 16'h0001) begin
									in_loop_reg <= 1'b0;
									replay_reg <= 1'b0;
									loop_events <= budget_reg;
								end else begin
									loop_cnt_reg <= loop_cnt_reg - 1'b1;
									replay_reg <= 1'b1;
									rd_ptr_reg <= '0;
								end
							end
							seq_pkg::OP_PULSE: begin
								state_reg <= seq_pkg::ST_PRE;
								gate_out <= cur_w[seq_pkg::GATE_MSB:seq_pkg::GATE_LSB];
								gate_out[seq_pkg::GATE_AMP] <= 1'b1;
								gate_out[seq_pkg::GATE_TX] <= 1'b0;
								tmr_ticks_reg <= ticks_of({28'h0000000, aux_w});
								tmr_start_reg <= 1'b1;
							end
							seq_pkg::OP_ACQUIRE: begin
								explicit_reg <= 1'b1;
								auto_acq_en <= 1'b0;
								pairs_left_reg <= {21'h000000, aux_w[11:1]};
								if (!acq_open_reg) begin
									acq_open_reg <= 1'b1;
									ovf_detect_en <= 1'b1;
								end
								if (!phase_locked_reg) begin
									rx_phase_out <= rx_phase_in;
									phase_locked_reg <= 1'b1;
								end
								if (aux_w[11:1] != 11'h000) begin
									state_reg <= seq_pkg::ST_SAMPLE;
									tmr_ticks_reg <= 40'(seq_pkg::PAIR_CYCLES);
									tmr_start_reg <= 1'b1;
									sample_strobe <= 1'b1;
								end
							end
							seq_pkg::OP_PHASE: begin
								gate_out <= cur_w[seq_pkg::GATE_MSB:seq_pkg::GATE_LSB];
							end
							default: begin
								// Plain timed event; zero length gives no event
								if (dur_w != 40'h0000000000) begin
									gate_out <= cur_w[seq_pkg::GATE_MSB:seq_pkg::GATE_LSB];
									tmr_ticks_reg <= ticks_of(dur_w);
									tmr_start_reg <= 1'b1;
									state_reg <= seq_pkg::ST_POST;
								end
							end
						endcase
					end
				end
				seq_pkg::ST_PRE: begin
					if (tmr_done) begin
						gate_out[seq_pkg::GATE_TX] <= 1'b1;
						tmr_ticks_reg <= ticks_of(word_reg[seq_pkg::DUR_MSB:seq_pkg::DUR_LSB]);
						tmr_start_reg <= 1'b1;
						state_reg <= seq_pkg::ST_WIDTH;
					end
				end
				seq_pkg::ST_WIDTH: begin
					if (tmr_done) begin
						gate_out[seq_pkg::GATE_TX] <= 1'b0;
						tmr_ticks_reg <= ticks_of(40'(word_reg[seq_pkg::GATE_LSB-1:seq_pkg::GATE_LSB-8]));
						tmr_start_reg <= 1'b1;
						state_reg <= seq_pkg::ST_POST;
					end
				end
				seq_pkg::ST_POST: begin
					if (tmr_done) begin
						state_reg <= seq_pkg::ST_FETCH;
					end
				end
				seq_pkg::ST_SAMPLE: begin
					if (tmr_done) begin
						points_reg <= points_reg + 32'h00000002;
						pairs_left_reg <= pairs_left_reg - 32'h00000001;
						// Sample interval is already in timer ticks; core cycles on the main controller
						tmr_ticks_reg <= word_reg[seq_pkg::DUR_MSB:seq_pkg::DUR_LSB]
							- 40'(seq_pkg::PAIR_CYCLES);
						tmr_start_reg <= 1'b1;
						state_reg <= seq_pkg::ST_WAIT;
					end
				end
				seq_pkg::ST_WAIT: begin
					if (tmr_done) begin
						if (pairs_left_reg == 32'h00000000) begin
							state_reg <= seq_pkg::ST_FETCH;
						end else begin
							tmr_ticks_reg <= 40'(seq_pkg::PAIR_CYCLES);
							tmr_start_reg <= 1'b1;
							sample_strobe <= 1'b1;
							state_reg <= seq_pkg::ST_SAMPLE;
						end
					end
				end
				seq_pkg::ST_HALT: state_reg <= seq_pkg::ST_HALT;
				default: state_reg <= seq_pkg::ST_FETCH;
			endcase
		end
	end

	// Timer on the fine base, or on the two small-system bases
	event_timer #(
		.DUR_W(40),
		.FINE_DIV(SMALL_SYSTEM ? FAST_DIV : 1), // Fine ticks arrive as core cycles
		.SLOW_DIV(SLOW_DIV * FAST_DIV)
	) u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(tmr_start_reg),
		.slow_base(tmr_slow_reg),
		.ticks(tmr_ticks_reg),
		.done(tmr_done)
	);

	// Zero count never arms a loop
	a_zero_loop: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_w && !err_flag && op_w == seq_pkg::OP_LOOP_START && !in_loop_reg
		&& dur_w[15:0] == 16'h0000 |=> err_flag && err_code == seq_pkg::ERR_ZERO_LOOP)
		else $error("zero loop count not flagged");
	// Count of one never enters loop mode
	a_single_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_w && !err_flag && op_w == seq_pkg::OP_LOOP_START && !in_loop_reg
		&& dur_w[15:0] == 16'h0001 |=> !in_loop_reg)
		else $error("count of one entered loop");
	// Second start inside a loop is an error
	a_no_nesting: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_w && !err_flag && op_w == seq_pkg::OP_LOOP_START && in_loop_reg
		|=> err_code == seq_pkg::ERR_NESTED)
		else $error("nested loop accepted");
	// Counter never exceeds limit
	a_count_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
		loop_cnt_reg <= seq_pkg::LOOP_MAX)
		else $error("loop counter above limit");
	// Transmitter off and amplifier on in the first cycle of the pre part of a pulse
	a_pulse_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_reg == seq_pkg::ST_PRE && $past(state_reg) == seq_pkg::ST_FETCH
		|-> !gate_out[seq_pkg::GATE_TX] && gate_out[seq_pkg::GATE_AMP])
		else $error("pulse pre-delay gates wrong");
	// Receiver phase held while a scan is locked
	a_phase_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		phase_locked_reg && $past(phase_locked_reg) && !(take_w && op_w == seq_pkg::OP_SEQ_START)
		|=> $stable(rx_phase_out))
		else $error("receiver phase changed mid scan");
	// Explicit acquisition turns automatic acquisition off
	a_auto_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_w && !err_flag && op_w == seq_pkg::OP_ACQUIRE |=> !auto_acq_en && ovf_detect_en)
		else $error("acquire left auto mode on");
	// Sequence start clears the table
	a_table_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_w && !err_flag && op_w == seq_pkg::OP_SEQ_START |=> table_clear)
		else $error("table not cleared at start");
endmodule

// >>> tb/prog_feed_model.sv
// Program FIFO feeder standing in for the acquisition computer.
// Assumes the sequencer takes a word at a rising edge with valid and ready high.
`timescale 1ns/100ps
module prog_feed_model (
	input wire logic core_clk,
	input wire logic prog_ready,
	input wire logic slow,
	output logic prog_valid,
	output logic [63:0] prog_data
);
	logic [63:0] q[$]; // Words waiting to be offered
	int seed = 32'h6549; // Stall pattern seed
	bit taken; // Word taken at the last edge
	initial begin
		prog_valid = 1'b0;
		prog_data = 64'h0;
	end
	// Queue one word behind the others
	task automatic push(input logic [63:0] wd);
		q.push_back(wd);
	endtask
	// Drop pending words and release the bus
	task automatic flush();
		q.delete();
		prog_valid = 1'b0;
		prog_data = ~prog_data;
	endtask
	// Offer words in order; hold each until taken, then show a changed pattern
	always @(posedge core_clk) begin
		taken = prog_valid && prog_ready;
		#1;
		if (taken && q.size() > 0) begin
			q.delete(0);
			prog_valid = 1'b0;
			prog_data = ~prog_data;
		end else if (!prog_valid && q.size() > 0 && (!slow || $random(seed) % 3 == 0)) begin
			// Slow mode stalls between words on purpose
			prog_valid = 1'b1;
			prog_data = q[0];
		end else if (!prog_valid) begin
			prog_data = ~prog_data;
		end
	end
endmodule

// >>> tb/test_loop_sequencer.sv
// Self-checking bench for the loop sequencer with a counting reference model.
// Assumes the feeder model and the sequencer package are compiled first.
`timescale 1ns/100ps
module test_loop_sequencer;
	logic core_clk; // Core clock
	logic sys_rst; // Synchronous reset
	logic prog_valid; // Word offered
	logic [63:0] prog_data; // Event word
	logic prog_ready; // Sequencer ready to take a word
	logic clear_table; // Clear request
	logic [1:0] rx_phase_in; // Receiver phase request
	logic [31:0] total_point_count; // Expected points
	logic [7:0] gate_out; // Gate lines
	logic sample_strobe; // Pair window start
	logic [1:0] rx_phase_out; // Latched phase
	logic ovf_detect_en; // Overflow detection
	logic auto_acq_en; // Implicit acquisition
	logic table_clear; // Table zeroing pulse
	logic seq_running; // Sequence active
	logic [2:0] err_code; // Error code
	logic err_flag; // Sticky error
	logic [11:0] loop_events; // Loop budget
	logic slow; // Feeder stalls
	logic tx_q; // Last transmitter gate
	logic [1:0] exp_phase; // Phase at first point
	logic [63:0] prog[$]; // Program under test
	int fails; // Mismatches
	int checked; // Comparisons
	int seed = 32'h6549; // Stimulus seed
	int n_tx; // Transmitter pulses seen
	int n_pairs; // Pair windows seen
	int n_clr; // Table clears seen
	int cnt_tab[3] = '{1, 2, 5}; // Loop counts tried
	loop_sequencer dut (.core_clk(core_clk), .sys_rst(sys_rst), .prog_data(prog_data),
		.prog_valid(prog_valid), .prog_ready(prog_ready), .clear_table(clear_table),
		.rx_phase_in(rx_phase_in), .total_point_count(total_point_count),
		.gate_out(gate_out), .sample_strobe(sample_strobe), .rx_phase_out(rx_phase_out),
		.ovf_detect_en(ovf_detect_en), .auto_acq_en(auto_acq_en),
		.table_clear(table_clear), .seq_running(seq_running), .err_code(err_code),
		.err_flag(err_flag), .loop_events(loop_events));
	prog_feed_model feed (.core_clk(core_clk), .prog_ready(prog_ready), .slow(slow),
		.prog_valid(prog_valid), .prog_data(prog_data));
	// Free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Compare a design output
	task automatic cmp_out(input logic [11:0] got, input logic [11:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	// Compare a count seen by the bench
	task automatic cmp_cnt(input int got, input int exp, input string msg);
		checked++;
		if (got != exp) begin
			fails++;
			$display("ERROR %0t %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic final_report();
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Build one event word with gates cleared
	function automatic logic [63:0] w(input logic [3:0] op, input logic [11:0] aux,
		input logic [39:0] dur);
		return {op, 8'h00, aux, dur};
	endfunction
	// Hold reset for eight cycles and empty the feeder
	task automatic do_reset();
		sys_rst = 1'b1;
		feed.flush();
		repeat (8) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
	endtask
	// Count pulses, pair windows and clears; check gate order and phase hold
	always @(posedge core_clk) begin
		if (!sys_rst) begin
			if (gate_out[seq_pkg::GATE_TX] === 1'b1 && tx_q !== 1'b1) n_tx++;
			if (gate_out[seq_pkg::GATE_TX] === 1'b1) begin
				cmp_out(gate_out[seq_pkg::GATE_AMP], 1'b1, "tx without amp");
			end
			if (sample_strobe === 1'b1) begin
				n_pairs++;
				cmp_out(rx_phase_out, exp_phase, "phase moved");
				cmp_out(ovf_detect_en, 1'b1, "overflow detect off");
			end
			if (table_clear === 1'b1) n_clr++;
		end
		tx_q = gate_out[seq_pkg::GATE_TX];
	end
	// Run the program through the model and the design, then compare
	task automatic run_prog(input int total);
		int mult, body, pts, pairs, tx, ev, i;
		bit in_loop, acq, flip;
		logic [2:0] err;
		logic [63:0] wd;
		mult = 1;
		body = 0;
		pts = 0;
		pairs = 0;
		tx = 0;
		ev = 0;
		in_loop = 0;
		acq = 0;
		flip = 0;
		err = seq_pkg::ERR_NONE;
		// Reference model: one loop level, counts scaled by repetitions
		foreach (prog[k]) begin
			wd = prog[k];
			if (err == seq_pkg::ERR_NONE) begin
				case (wd[63:60])
					seq_pkg::OP_LOOP_START: begin
						if (in_loop) err = seq_pkg::ERR_NESTED;
						else if (wd[15:0] == 16'h0) err = seq_pkg::ERR_ZERO_LOOP;
						else begin
							in_loop = 1;
							mult = wd[15:0];
							body = 0;
						end
					end
					seq_pkg::OP_LOOP_END: begin
						if (mult > 1) ev = body;
						in_loop = 0;
						mult = 1;
					end
					seq_pkg::OP_PULSE: begin
						tx += mult;
						body += 3;
					end
					seq_pkg::OP_EVENT: body += 1;
					seq_pkg::OP_OFFSET: body += 9;
					seq_pkg::OP_ACQUIRE: begin
						acq = 1;
						body += wd[51:40];
						pts += mult * wd[51:40];
						pairs += mult * wd[51:40] / 2;
					end
					seq_pkg::OP_SEQ_END: if (acq && pts != total) err = seq_pkg::ERR_POINTS;
					default: ;
				endcase
			end
		end
		do_reset();
		n_tx = 0;
		n_pairs = 0;
		n_clr = 0;
		slow = $random(seed);
		rx_phase_in = $random(seed);
		exp_phase = rx_phase_in;
		total_point_count = total;
		foreach (prog[k]) feed.push(prog[k]);
		i = 0;
		// Wait for the end of the sequence or an error, bounded
		while (i < 20000 && err_flag !== 1'b1 &&
			!(feed.q.size() == 0 && prog_valid === 1'b0 && seq_running === 1'b0)) begin
			@(posedge core_clk);
			#1;
			// Phase changes after the first point must be ignored
			if (n_pairs > 0 && !flip) begin
				rx_phase_in = ~exp_phase;
				flip = 1;
			end
			i++;
		end
		repeat (3) @(posedge core_clk);
		#1;
		cmp_cnt(i < 20000, 1, "run hung");
		cmp_out(err_code, err, "error code");
		cmp_out(err_flag, err != seq_pkg::ERR_NONE, "error flag");
		if (err == seq_pkg::ERR_NONE) begin
			cmp_cnt(n_tx, tx, "pulse count");
			cmp_cnt(n_pairs, pairs, "pair count");
			cmp_cnt(n_clr > 0, 1, "start clear");
			cmp_out(auto_acq_en, !acq, "auto acquisition");
			cmp_out(ovf_detect_en, 1'b0, "overflow detect left on");
			cmp_out(loop_events, ev, "loop budget");
		end else if (err != seq_pkg::ERR_POINTS) begin
			cmp_cnt(feed.q.size() > 0, 1, "words taken after error");
		end
	endtask
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		clear_table = 1'b0;
		rx_phase_in = 2'h0;
		total_point_count = 32'h0;
		slow = 1'b0;
		exp_phase = 2'h0;
		tx_q = 1'b0;
		fails = 0;
		checked = 0;
		do_reset();
		cmp_out({auto_acq_en, ovf_detect_en, seq_running, err_flag, table_clear,
			sample_strobe}, 12'h020, "reset values");
		cmp_out(gate_out, 12'h000, "reset gates");
		clear_table = 1'b1;
		@(posedge core_clk);
		#1;
		clear_table = 1'b0;
		cmp_out(table_clear, 1'b1, "table clear");
		@(posedge core_clk);
		#1;
		cmp_out(table_clear, 1'b0, "table clear end");
		// Loop bodies of four statements with counts one, two and five; one loop per
		// sequence, so no loop ever follows another
		foreach (cnt_tab[j]) begin
			prog = '{w(seq_pkg::OP_SEQ_START, 0, 0), w(seq_pkg::OP_PULSE, 12'h012, 3),
				w(seq_pkg::OP_LOOP_START, 0, cnt_tab[j]), w(seq_pkg::OP_PULSE, 12'h012, 3),
				w(seq_pkg::OP_EVENT, 0, 4), w(seq_pkg::OP_OFFSET, 0, 0),
				w(seq_pkg::OP_PHASE, 0, 0), w(seq_pkg::OP_LOOP_END, 0, 0),
				w(seq_pkg::OP_SEQ_END, 0, 0)};
			run_prog(0);
		end
		// Looped and split acquisition, right and wrong point totals
		prog = '{w(seq_pkg::OP_SEQ_START, 0, 0), w(seq_pkg::OP_LOOP_START, 0, 3),
			w(seq_pkg::OP_ACQUIRE, 4, 30), w(seq_pkg::OP_EVENT, 0, 4),
			w(seq_pkg::OP_LOOP_END, 0, 0), w(seq_pkg::OP_ACQUIRE, 2, 30),
			w(seq_pkg::OP_SEQ_END, 0, 0)};
		run_prog(14);
		run_prog(12);
		// Zero repetition count
		prog = '{w(seq_pkg::OP_SEQ_START, 0, 0), w(seq_pkg::OP_LOOP_START, 0, 0),
			w(seq_pkg::OP_EVENT, 0, 4), w(seq_pkg::OP_EVENT, 0, 4),
			w(seq_pkg::OP_LOOP_END, 0, 0), w(seq_pkg::OP_SEQ_END, 0, 0)};
		run_prog(0);
		// Second loop start inside a loop
		prog = '{w(seq_pkg::OP_SEQ_START, 0, 0), w(seq_pkg::OP_LOOP_START, 0, 2),
			w(seq_pkg::OP_LOOP_START, 0, 2), w(seq_pkg::OP_EVENT, 0, 4),
			w(seq_pkg::OP_EVENT, 0, 4), w(seq_pkg::OP_LOOP_END, 0, 0),
			w(seq_pkg::OP_SEQ_END, 0, 0)};
		run_prog(0);
		final_report();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge core_clk);
		fails++;
		final_report();
	end
endmodule
